// ### core/ums_pkg.sv
// constants, types and field layout of the uart mode and status registers
// ---------------------------------------------------------------------------
// Overview of operation
// - attention bit self-clears on nine-bit address frame
// - force break holds transmit output low
// - transmit dma enable suppresses transmit interrupts
// - receive dma enable suppresses receive data interrupts
// - receive error interrupts ignore receive dma enable
// - flow control enable gates flow interrupts
// - request-to-send bit drives active-low rts pin
// - mode register byte wide, read/write, resets zero
// - mode bit positions 7,6,5,4,2,1
// - status register read-only, resets zero, ignores writes
// - parity flag set on error, cleared by read
// - framing flag set on missing stop, read clears
// - overrun flag set on unread buffer, read clears
// - summary error high while parity, framing or overrun flag set
// - break after ten low bit times, clear rules
// ---------------------------------------------------------------------------
package ums_pkg;

  // -------------------------------------------------------------------------
  // register byte offsets on the bus
  // -------------------------------------------------------------------------
  localparam logic [7:0] UMS_MODE_OFS = 8'h00;
  localparam logic [7:0] UMS_STATUS_OFS = 8'h04;
  localparam logic [7:0] UMS_IRQ_STAT_OFS = 8'h08;
  localparam logic [7:0] UMS_IRQ_CLR_OFS = 8'h0C;
  localparam logic [7:0] UMS_IRQ_EN_OFS = 8'h10;

  // -------------------------------------------------------------------------
  // mode register fields and reset value
  // -------------------------------------------------------------------------
  localparam int UMS_MODE_RTS = 7;
  localparam int UMS_MODE_FLOW = 6;
  localparam int UMS_MODE_RXDMA = 5;
  localparam int UMS_MODE_TXDMA = 4;
  localparam int UMS_MODE_BRK = 2;
  localparam int UMS_MODE_ATTN = 1;
  localparam logic [7:0] UMS_MODE_RST = 8'h00;
  // reserved bits 3 and 0 are never stored
  localparam logic [7:0] UMS_MODE_WR_MASK = 8'hF6;

  // -------------------------------------------------------------------------
  // line status fields and reset value
  // -------------------------------------------------------------------------
  localparam int UMS_ST_PARITY = 0;
  localparam int UMS_ST_FRAME = 1;
  localparam int UMS_ST_OVERRUN = 2;
  localparam int UMS_ST_SUMMARY = 3;
  localparam int UMS_ST_BREAK = 4;
  localparam logic [7:0] UMS_STATUS_RST = 8'h00;

  // -------------------------------------------------------------------------
  // interrupt status / clear / enable layout
  // -------------------------------------------------------------------------
  localparam int UMS_IRQ_W = 4;
  localparam int UMS_IRQ_TX = 0;
  localparam int UMS_IRQ_RX = 1;
  localparam int UMS_IRQ_ERR = 2;
  localparam int UMS_IRQ_FLOW = 3;
  localparam logic [3:0] UMS_IRQ_RST = 4'h0;

  // -------------------------------------------------------------------------
  // break detection: low bit times before a break is flagged
  // -------------------------------------------------------------------------
  localparam logic [3:0] UMS_BREAK_BITS = 4'hA;

  // break detector states, gray along idle -> count -> held
  typedef enum logic [1:0] {
    UMS_BRK_IDLE = 2'b00,
    UMS_BRK_COUNT = 2'b01,
    UMS_BRK_HELD = 2'b11
  } ums_brk_e;

  // end-of-character report from the receiver shift logic
  typedef struct packed {
    logic charDone;
    logic ninthBit;
    logic nineBitFrame;
    logic parityErr;
    logic stopMissing;
  } ums_rxev_s;

endpackage : ums_pkg

// ### core/ums_regs.sv
// wishbone register block: second mode register, line status, interrupts
//
// The placing of the registers and the Wishbone interface to the registers are this design's own decisions.
`timescale 1ns/1ps

module ums_regs
  import ums_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  // wishbone classic slave
  input wire logic wbCyc,
  input wire logic wbStb,
  input wire logic wbWe,
  input wire logic [7:0] wbAdr,
  input wire logic [3:0] wbSel,
  input wire logic [31:0] wbDatI,
  output logic [31:0] wbDatO,
  output logic wbAck,
  // receiver side
  input wire ums_rxev_s rxEvt,
  input wire logic rxFull,
  input wire logic rxd,
  input wire logic bitTick,
  // transmitter side
  input wire logic txSerial,
  input wire logic txEmpty,
  input wire logic txDoneEvt,
  input wire logic flowEvt,
  // line and system outputs
  output logic txd,
  output logic rtsN,
  output logic txDmaReq,
  output logic rxDmaReq,
  output logic attentionMode,
  output logic irq
);

  // -------------------------------------------------------------------------
  // state
  // -------------------------------------------------------------------------
  logic [7:0] modeReg;
  logic [7:0] next_modeReg;
  logic parityFlag;
  logic next_parityFlag;
  logic frameFlag;
  logic next_frameFlag;
  logic overrunFlag;
  logic next_overrunFlag;
  logic breakFlag;
  logic next_breakFlag;
  logic breakPending;
  logic next_breakPending;
  ums_brk_e brkState;
  ums_brk_e next_brkState;
  logic [3:0] brkCount;
  logic [3:0] next_brkCount;
  logic [3:0] irqStat;
  logic [3:0] next_irqStat;
  logic [3:0] irqEn;
  logic [3:0] next_irqEn;
  logic [31:0] next_wbDatO;
  logic next_wbAck;
  logic next_txd;
  logic next_rtsN;
  logic next_txDmaReq;
  logic next_rxDmaReq;
  logic next_irq;
  logic next_attentionMode;

  // decoded bus strobes, valid only in the cycle a request is taken
  logic take;
  logic wrLow;
  logic statusRead;
  logic [7:0] statusView;
  logic summary;
  logic [3:0] irqEvt;
  logic [3:0] irqGate;

  // -------------------------------------------------------------------------
  // bus decode
  // -------------------------------------------------------------------------
  // a request is taken once; ack then drops for one cycle before the next
  // only sel[0] qualifies a write; upper lanes carry no register
  always_comb begin
    take = wbCyc && wbStb && !wbAck;
    wrLow = take && wbWe && wbSel[0];
    statusRead = take && !wbWe && (wbAdr == UMS_STATUS_OFS);
  end

  // -------------------------------------------------------------------------
  // second mode register
  // -------------------------------------------------------------------------
  // software write wins over the hardware clear of attention in one cycle
  always_comb begin
    next_modeReg = modeReg;
    if (rxEvt.charDone && rxEvt.nineBitFrame && rxEvt.ninthBit) begin
      next_modeReg[UMS_MODE_ATTN] = 1'b0;
    end
    if (wrLow && wbAdr == UMS_MODE_OFS) begin
      // reserved positions never stored, so they read back zero
      next_modeReg = wbDatI[7:0] & UMS_MODE_WR_MASK;
    end
  end

  // mode byte; reset clears every bit
  always_ff @(posedge clk) begin
    if (srst) begin
      modeReg <= UMS_MODE_RST;
    end else begin
      modeReg <= next_modeReg;
    end
  end

  // -------------------------------------------------------------------------
  // line status error flags
  // -------------------------------------------------------------------------
  // a new error in the cycle of a status read survives the read
  always_comb begin
    next_parityFlag = parityFlag;
    next_frameFlag = frameFlag;
    next_overrunFlag = overrunFlag;
    if (statusRead) begin
      next_parityFlag = 1'b0;
      next_frameFlag = 1'b0;
      next_overrunFlag = 1'b0;
    end
    if (rxEvt.charDone && rxEvt.parityErr) begin
      next_parityFlag = 1'b1;
    end
    if (rxEvt.charDone && rxEvt.stopMissing) begin
      next_frameFlag = 1'b1;
    end
    if (rxEvt.charDone && rxFull) begin
      next_overrunFlag = 1'b1;
    end
  end

  // error flags; reset clears the whole status byte
  always_ff @(posedge clk) begin
    if (srst) begin
      parityFlag <= UMS_STATUS_RST[UMS_ST_PARITY];
      frameFlag <= UMS_STATUS_RST[UMS_ST_FRAME];
      overrunFlag <= UMS_STATUS_RST[UMS_ST_OVERRUN];
    end else begin
      parityFlag <= next_parityFlag;
      frameFlag <= next_frameFlag;
      overrunFlag <= next_overrunFlag;
    end
  end

  // -------------------------------------------------------------------------
  // break detector
  // -------------------------------------------------------------------------
  // counts bit-time ticks while the line stays low after a bad stop bit;
  // a read while the line is still low only arms the clear
  // limitation: ticks count from the end-of-character report, so the
  // first counted bit time may be a partial one
  always_comb begin
    next_brkState = brkState;
    next_brkCount = brkCount;
    next_breakFlag = breakFlag;
    next_breakPending = breakPending;
    case (brkState)
      UMS_BRK_IDLE: begin
        next_brkCount = 4'h0;
        if (rxEvt.charDone && rxEvt.stopMissing && !rxd) begin
          next_brkState = UMS_BRK_COUNT;
        end
      end
      UMS_BRK_COUNT: begin
        if (rxd) begin
          next_brkState = UMS_BRK_IDLE;
        end else if (bitTick) begin
          next_brkCount = brkCount + 4'h1;
          if (brkCount + 4'h1 == UMS_BREAK_BITS) begin
            next_brkState = UMS_BRK_HELD;
          end
        end
      end
      UMS_BRK_HELD: begin
        if (rxd) begin
          next_brkState = UMS_BRK_IDLE;
        end
      end
      default: begin
        next_brkState = UMS_BRK_IDLE;
      end
    endcase
    // clear: read with line high, or line back high after an early read
    if (statusRead && rxd) begin
      next_breakFlag = 1'b0;
      next_breakPending = 1'b0;
    end else if (statusRead && breakFlag) begin
      next_breakPending = 1'b1;
    end
    if (breakPending && rxd) begin
      next_breakFlag = 1'b0;
      next_breakPending = 1'b0;
    end
    // detection wins over any clear in the same cycle
    if (brkState == UMS_BRK_COUNT && !rxd && bitTick &&
        brkCount + 4'h1 == UMS_BREAK_BITS) begin
      next_breakFlag = 1'b1;
      next_breakPending = 1'b0;
    end
  end

  // break detector state, counter and flags
  always_ff @(posedge clk) begin
    if (srst) begin
      brkState <= UMS_BRK_IDLE;
      brkCount <= 4'h0;
      breakFlag <= UMS_STATUS_RST[UMS_ST_BREAK];
      breakPending <= 1'b0;
    end else begin
      brkState <= next_brkState;
      brkCount <= next_brkCount;
      breakFlag <= next_breakFlag;
      breakPending <= next_breakPending;
    end
  end

  // -------------------------------------------------------------------------
  // status view
  // -------------------------------------------------------------------------
  // summary is derived, so it can never disagree with the three flags
  // bits 7..5 have no source and read zero
  always_comb begin
    summary = parityFlag || frameFlag || overrunFlag;
    statusView = 8'h00;
    statusView[UMS_ST_PARITY] = parityFlag;
    statusView[UMS_ST_FRAME] = frameFlag;
    statusView[UMS_ST_OVERRUN] = overrunFlag;
    statusView[UMS_ST_SUMMARY] = summary;
    statusView[UMS_ST_BREAK] = breakFlag;
  end

  // -------------------------------------------------------------------------
  // interrupt status, clear and enable
  // -------------------------------------------------------------------------
  // events latch even while gated, so software can still poll them
  always_comb begin
    irqEvt = 4'h0;
    irqEvt[UMS_IRQ_TX] = txDoneEvt;
    irqEvt[UMS_IRQ_RX] = rxEvt.charDone;
    irqEvt[UMS_IRQ_ERR] = rxEvt.charDone &&
      (rxEvt.parityErr || rxEvt.stopMissing || rxFull);
    irqEvt[UMS_IRQ_FLOW] = flowEvt;
    // dma owns data movement, so its data interrupts are masked here
    irqGate = 4'hF;
    irqGate[UMS_IRQ_TX] = !modeReg[UMS_MODE_TXDMA];
    irqGate[UMS_IRQ_RX] = !modeReg[UMS_MODE_RXDMA];
    irqGate[UMS_IRQ_ERR] = 1'b1;
    irqGate[UMS_IRQ_FLOW] = modeReg[UMS_MODE_FLOW];
    // clear and enable writes use only the low nibble
    next_irqStat = irqStat;
    next_irqEn = irqEn;
    if (wrLow && wbAdr == UMS_IRQ_CLR_OFS) begin
      next_irqStat = irqStat & ~wbDatI[3:0];
    end
    if (wrLow && wbAdr == UMS_IRQ_EN_OFS) begin
      next_irqEn = wbDatI[3:0];
    end
    // set wins over a clear in the same cycle
    next_irqStat = next_irqStat | irqEvt;
  end

  // sticky interrupt bits and their enables
  always_ff @(posedge clk) begin
    if (srst) begin
      irqStat <= UMS_IRQ_RST;
      irqEn <= UMS_IRQ_RST;
    end else begin
      irqStat <= next_irqStat;
      irqEn <= next_irqEn;
    end
  end

  // -------------------------------------------------------------------------
  // bus answer
  // -------------------------------------------------------------------------
  // one wait state; unmapped and write-only addresses read zero, still acked
  always_comb begin
    next_wbAck = take;
    next_wbDatO = wbDatO;
    if (take) begin
      next_wbDatO = 32'h0000_0000;
      if (!wbWe) begin
        case (wbAdr)
          UMS_MODE_OFS: next_wbDatO[7:0] = modeReg;
          // writes to status decode to nothing and change no bit
          UMS_STATUS_OFS: next_wbDatO[7:0] = statusView;
          UMS_IRQ_STAT_OFS: next_wbDatO[3:0] = irqStat;
          UMS_IRQ_EN_OFS: next_wbDatO[3:0] = irqEn;
          default: next_wbDatO = 32'h0000_0000;
        endcase
      end
    end
  end

  // ack and read data leave straight from flip-flops
  always_ff @(posedge clk) begin
    if (srst) begin
      wbAck <= 1'b0;
      wbDatO <= 32'h0000_0000;
    end else begin
      wbAck <= next_wbAck;
      wbDatO <= next_wbDatO;
    end
  end

  // -------------------------------------------------------------------------
  // line and system outputs
  // -------------------------------------------------------------------------
  // all outputs registered; one cycle behind the mode register
  always_comb begin
    next_txd = txSerial && !modeReg[UMS_MODE_BRK];
    // the pin is active low, so a set bit pulls it down
    next_rtsN = !modeReg[UMS_MODE_RTS];
    next_txDmaReq = modeReg[UMS_MODE_TXDMA] && txEmpty;
    next_rxDmaReq = modeReg[UMS_MODE_RXDMA] && rxFull;
    next_irq = |(irqStat & irqEn & irqGate);
    next_attentionMode = modeReg[UMS_MODE_ATTN];
  end

  // idle line levels out of reset: txd high, rts released
  always_ff @(posedge clk) begin
    if (srst) begin
      txd <= 1'b1;
      rtsN <= 1'b1;
      txDmaReq <= 1'b0;
      rxDmaReq <= 1'b0;
      attentionMode <= 1'b0;
      irq <= 1'b0;
    end else begin
      txd <= next_txd;
      rtsN <= next_rtsN;
      txDmaReq <= next_txDmaReq;
      rxDmaReq <= next_rxDmaReq;
      attentionMode <= next_attentionMode;
      irq <= next_irq;
    end
  end

endmodule : ums_regs

// ### tb/ums_chk.sv
// assertion checker for the uart mode and status register block
`timescale 1ns/1ps
module ums_chk
  import ums_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic wbCyc,
  input wire logic wbStb,
  input wire logic wbWe,
  input wire logic [7:0] wbAdr,
  input wire logic [3:0] wbSel,
  input wire logic [31:0] wbDatI,
  input wire logic [31:0] wbDatO,
  input wire logic wbAck,
  input wire ums_rxev_s rxEvt,
  input wire logic rxFull,
  input wire logic txEmpty,
  input wire logic txd,
  input wire logic rtsN,
  input wire logic txDmaReq,
  input wire logic rxDmaReq,
  input wire logic attentionMode
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  logic take;
  logic wrMode;
  logic attnHit;
  // request taken, mode write, address frame seen
  assign take = wbCyc & wbStb & !wbAck;
  assign wrMode = take & wbWe & wbSel[0] & (wbAdr == UMS_MODE_OFS);
  assign attnHit = rxEvt.charDone & rxEvt.nineBitFrame & rxEvt.ninthBit;
  // status read: take, then the acked data beat
  sequence s_rd_stat;
    take && !wbWe && wbAdr == UMS_STATUS_OFS ##1 wbAck;
  endsequence
  sequence s_wr_brk;
    wrMode && wbDatI[UMS_MODE_BRK] ##1 wbAck;
  endsequence
  property p_ack;
    take |=> wbAck ##1 !wbAck;
  endproperty
  a_ack: assert property (p_ack) else $error("ack not a single pulse");
  property p_brk;
    s_wr_brk |=> !txd;
  endproperty
  a_brk: assert property (p_brk) else $error("break not low");
  property p_rts;
    wrMode |-> ##2 rtsN == !$past(wbDatI[UMS_MODE_RTS], 2);
  endproperty
  a_rts: assert property (p_rts) else $error("rts pin wrong");
  property p_txdma;
    wrMode |-> ##2 txDmaReq == ($past(wbDatI[4], 2) & $past(txEmpty));
  endproperty
  a_txdma: assert property (p_txdma) else $error("tx dma wrong");
  property p_rxdma;
    wrMode |-> ##2 rxDmaReq == ($past(wbDatI[5], 2) & $past(rxFull));
  endproperty
  a_rxdma: assert property (p_rxdma) else $error("rx dma wrong");
  property p_attn;
    attnHit && !wrMode |-> ##2 !attentionMode;
  endproperty
  a_attn: assert property (p_attn) else $error("attn kept");
  property p_sum;
    s_rd_stat |-> wbDatO[UMS_ST_SUMMARY] == |wbDatO[2:0];
  endproperty
  a_sum: assert property (p_sum) else $error("summary wrong");
  property p_hi;
    s_rd_stat |-> wbDatO[7:5] == 3'h0;
  endproperty
  a_hi: assert property (p_hi) else $error("status high bits");
endmodule : ums_chk

bind ums_regs ums_chk ums_chk_i (.clk(clk), .srst(srst), .wbCyc(wbCyc),
  .wbStb(wbStb), .wbWe(wbWe), .wbAdr(wbAdr), .wbSel(wbSel),
  .wbDatI(wbDatI), .wbDatO(wbDatO), .wbAck(wbAck), .rxEvt(rxEvt),
  .rxFull(rxFull), .txEmpty(txEmpty), .txd(txd), .rtsN(rtsN),
  .txDmaReq(txDmaReq), .rxDmaReq(rxDmaReq), .attentionMode(attentionMode));

// ### tb/ums_line_model.sv
// remote serial device: receive line, bit ticks and end-of-char reports
`timescale 1ns/1ps
module ums_line_model
  import ums_pkg::*;
(
  input wire logic clk,
  output ums_rxev_s rxEvt,
  output logic rxd,
  output logic bitTick
);
  logic [1:0] div = 2'h0;
  initial begin
    rxEvt = '0;
    rxd = 1'b1;
    bitTick = 1'b0;
  end
  // bit time of four clocks keeps break waits short
  always @(posedge clk) begin
    div <= div + 2'h1;
    bitTick <= (div == 2'h3);
  end
  // end of a character; low holds the line in break
  task automatic finish_char(input logic [3:0] f, input logic low);
    @(posedge clk);
    rxEvt <= {1'b1, f};
    rxd <= !low;
    @(posedge clk);
    rxEvt <= '0;
  endtask : finish_char
  task automatic release_line;
    @(posedge clk);
    rxd <= 1'b1;
  endtask : release_line
endmodule : ums_line_model

// ### tb/ums_regs_tb.sv
// self-checking bench of the uart mode and status register block
`timescale 1ns/1ps
module ums_regs_tb;
  import ums_pkg::*;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic wbCyc = 1'b0;
  logic wbStb = 1'b0;
  logic wbWe = 1'b0;
  logic [7:0] wbAdr = 8'h00;
  logic [3:0] wbSel = 4'h0;
  logic txSerial = 1'b1;
  logic txEmpty = 1'b1;
  logic [31:0] wbDatI = 32'h0;
  logic [31:0] wbDatO;
  logic wbAck;
  ums_rxev_s rxEvt;
  logic rxFull = 1'b0;
  logic rxd;
  logic bitTick;
  logic txDoneEvt = 1'b0;
  logic flowEvt = 1'b0;
  logic txd, rtsN, txDmaReq, rxDmaReq, attentionMode, irq;
  logic [31:0] pins;
  int n_mismatch = 0;
  int comparisons = 0;
  always #4 clk = ~clk;
  // pins as one word: txd rts txdma rxdma attn irq
  assign pins = {26'h0, txd, rtsN, txDmaReq, rxDmaReq, attentionMode, irq};
  ums_regs ums_regs_i (.clk(clk), .srst(srst), .wbCyc(wbCyc),
    .wbStb(wbStb), .wbWe(wbWe), .wbAdr(wbAdr), .wbSel(wbSel),
    .wbDatI(wbDatI), .wbDatO(wbDatO), .wbAck(wbAck), .rxEvt(rxEvt),
    .rxFull(rxFull), .rxd(rxd), .bitTick(bitTick), .txSerial(txSerial),
    .txEmpty(txEmpty), .txDoneEvt(txDoneEvt), .flowEvt(flowEvt), .txd(txd),
    .rtsN(rtsN), .txDmaReq(txDmaReq), .rxDmaReq(rxDmaReq),
    .attentionMode(attentionMode), .irq(irq));
  ums_line_model ums_line_model_i (.clk(clk), .rxEvt(rxEvt), .rxd(rxd),
    .bitTick(bitTick));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // classic cycle; no ack count assumed, watchdog ends a hang
  task automatic bus(input logic we, input logic [7:0] a,
    input logic [7:0] d, output logic [31:0] q);
    @(posedge clk);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= we;
    wbSel <= 4'hF;
    wbAdr <= a;
    wbDatI <= {24'h0, d};
    do @(posedge clk); while (wbAck !== 1'b1);
    q = wbDatO;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 8'h00, q);
    chk(q, exp);
  endtask : rd
  // let registered pins and irq land, then look mid-cycle
  task automatic settle;
    repeat (3) @(posedge clk);
    @(negedge clk);
  endtask : settle
  task automatic t_reset;
    rd(UMS_MODE_OFS, 32'h0);
    rd(UMS_STATUS_OFS, 32'h0);
    rd(8'h20, 32'h0);
    settle;
    chk(pins, 32'h30);
    $display("reset test done");
  endtask : t_reset
  task automatic t_mode;
    wr(UMS_MODE_OFS, 8'hF6);
    rd(UMS_MODE_OFS, 32'hF6);
    settle;
    chk(pins, 32'h0A);
    @(posedge clk);
    txEmpty <= 1'b0;
    settle;
    chk(pins, 32'h02);
    @(posedge clk);
    txEmpty <= 1'b1;
    wr(UMS_STATUS_OFS, 8'hFF);
    rd(UMS_STATUS_OFS, 32'h0);
    rxFull <= 1'b1;
    wr(UMS_MODE_OFS, 8'h20);
    settle;
    chk(pins, 32'h34);
    @(posedge clk);
    txSerial <= 1'b0;
    settle;
    chk(pins, 32'h14);
    @(posedge clk);
    txSerial <= 1'b1;
    rxFull <= 1'b0;
    $display("mode test done");
  endtask : t_mode
  task automatic t_gate;
    wr(UMS_IRQ_EN_OFS, 8'h0F);
    wr(UMS_MODE_OFS, 8'h30);
    @(posedge clk);
    txDoneEvt <= 1'b1;
    flowEvt <= 1'b1;
    @(posedge clk);
    txDoneEvt <= 1'b0;
    flowEvt <= 1'b0;
    ums_line_model_i.finish_char(4'h0, 1'b0);
    settle;
    chk(pins, 32'h38);
    rd(UMS_IRQ_STAT_OFS, 32'h0B);
    wr(UMS_MODE_OFS, 8'h20);
    settle;
    chk(pins, 32'h31);
    wr(UMS_IRQ_CLR_OFS, 8'h01);
    settle;
    chk(pins, 32'h30);
    wr(UMS_MODE_OFS, 8'h60);
    settle;
    chk(pins, 32'h31);
    wr(UMS_IRQ_CLR_OFS, 8'h08);
    wr(UMS_MODE_OFS, 8'h00);
    settle;
    chk(pins, 32'h31);
    wr(UMS_IRQ_CLR_OFS, 8'h02);
    rd(UMS_IRQ_STAT_OFS, 32'h0);
    $display("gate test done");
  endtask : t_gate
  task automatic t_err;
    wr(UMS_MODE_OFS, 8'h20);
    wr(UMS_IRQ_EN_OFS, 8'h04);
    ums_line_model_i.finish_char(4'h2, 1'b0);
    settle;
    chk(pins, 32'h31);
    rd(UMS_STATUS_OFS, 32'h09);
    rd(UMS_STATUS_OFS, 32'h00);
    rxFull <= 1'b1;
    ums_line_model_i.finish_char(4'h0, 1'b0);
    rxFull <= 1'b0;
    rd(UMS_STATUS_OFS, 32'h0C);
    wr(UMS_IRQ_CLR_OFS, 8'h0F);
    wr(UMS_IRQ_EN_OFS, 8'h00);
    wr(UMS_MODE_OFS, 8'h02);
    ums_line_model_i.finish_char(4'h8, 1'b0);
    rd(UMS_MODE_OFS, 32'h02);
    ums_line_model_i.finish_char(4'hC, 1'b0);
    rd(UMS_MODE_OFS, 32'h00);
    $display("error and attention test done");
  endtask : t_err
  task automatic t_brk;
    ums_line_model_i.finish_char(4'h1, 1'b1);
    repeat (60) @(posedge clk);
    rd(UMS_STATUS_OFS, 32'h1A);
    rd(UMS_STATUS_OFS, 32'h10);
    ums_line_model_i.release_line;
    settle;
    rd(UMS_STATUS_OFS, 32'h00);
    $display("break test done");
  endtask : t_brk
  // mid-run reset clears a written mode byte and a set flag
  task automatic t_rerst;
    wr(UMS_MODE_OFS, 8'hF6);
    ums_line_model_i.finish_char(4'h2, 1'b0);
    @(posedge clk);
    srst <= 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    rd(UMS_MODE_OFS, 32'h0);
    rd(UMS_STATUS_OFS, 32'h0);
    settle;
    chk(pins, 32'h30);
    $display("mid-run reset test done");
  endtask : t_rerst
  task automatic complete_run;
    $display("compares %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : complete_run
  // main sequence after two reset cycles
  initial begin
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    t_reset;
    t_mode;
    t_gate;
    t_err;
    t_brk;
    t_rerst;
    complete_run;
  end
  // tests need under 2000 cycles
  initial begin
    repeat (5000) @(posedge clk);
    n_mismatch++;
    complete_run;
  end
endmodule : ums_regs_tb
